// File: core/fe_ctrl_consts.svh
`ifndef FE_CTRL_CONSTS_SVH
`define FE_CTRL_CONSTS_SVH

// Register byte offsets
`define OFS_LVL_CFG        8'h00
`define OFS_LVL_START      8'h04
`define OFS_FREQ_HOLD      8'h08
`define OFS_PHASE_HOLD     8'h0C
`define OFS_FREQ_STB       8'h10
`define OFS_PHASE_STB      8'h14
`define OFS_NCO_SYNC_CFG   8'h18
`define OFS_LVL_RESULT     8'h1C
`define OFS_LVL_STATUS     8'h20

// Field positions
`define BIT_INTEG_MODE     30
`define INTERVAL_MSB       29
`define INTERVAL_LSB       14
`define THRESH_MSB         13
`define PHASE_MSB          9
`define BIT_SYNC_EN        20
`define BIT_INPUT_MODE     17
`define BIT_LOAD_ON_UPD    0
`define BIT_STAT_NEW       0
`define BIT_STAT_RUN       1

// Reset values
`define RST_WORD           32'h0000_0000
`define RST_PHASE          10'h000

// Counter timing: one preload unit is four sample clocks, minus one unit of bias
`define PRELOAD_SHIFT      2
`define PRELOAD_BIAS       18'h00004

`endif

// File: core/fe_ctrl_pkg.sv
package fe_ctrl_pkg;

    // Level detector configuration word fields
    typedef struct packed {
        logic        cont_mode;
        logic [15:0] interval;
        logic [13:0] threshold;
    } level_cfg_t;

    // Active carrier NCO controls handed to the datapath
    typedef struct packed {
        logic [31:0] freq;
        logic [9:0]  phase;
        logic        clear_fb;
    } nco_ctrl_t;

    typedef enum logic {INTEG_IDLE, INTEG_RUN} integ_state_t;

endpackage

// File: core/front_end_level_nco_control.sv
// Added by the designer: strobed register access and the address map.
`include "fe_ctrl_consts.svh"

module front_end_level_nco_control
    import fe_ctrl_pkg::*;
#(
    parameter int ACC_W = 32
) (
    // Clock and reset (front-end sample clock)
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata_ff,
    // Input samples, same clock domain
    input  wire logic [13:0]       sample_data,
    input  wire logic              sample_en,
    // Asynchronous carrier sync pin
    input  wire logic              carrier_sync_input,
    // Active controls toward the datapath
    output nco_ctrl_t              nco_ctrl_ff,
    output logic                   level_running_ff,
    output logic                   level_new_ff
);

    // Address match for a write or read at one offset
    function automatic logic hit(input logic strobe, input logic [7:0] addr,
                                 input logic [7:0] ofs);
        hit = strobe && (addr == ofs);
    endfunction

    // Two's complement magnitude of a 14-bit sample; -8192 still fits
    function automatic logic [13:0] magnitude(input logic [13:0] s);
        magnitude = s[13] ? 14'(~s + 14'h0001) : s;
    endfunction

    // Configuration state
    level_cfg_t   cfg_ff, nxt_cfg;
    logic         sync_en_ff, nxt_sync_en;
    logic         load_upd_ff, nxt_load_upd;
    logic         interp_ff, nxt_interp;
    // Holding registers
    logic [31:0]  freq_hold_ff, nxt_freq_hold;
    logic [9:0]   phase_hold_ff, nxt_phase_hold;
    // Active NCO controls
    nco_ctrl_t    nxt_nco;
    // Level detector datapath
    logic [13:0]  held_sample_ff, nxt_held_sample;
    logic signed [15:0] term_ff, nxt_term;
    logic         start_ff, nxt_start;
    logic [31:0]  result_ff, nxt_result;
    logic         nxt_new;
    logic [31:0]  nxt_rdata;
    // Wires from the submodules
    logic             sync_rise;
    logic [ACC_W-1:0] integ_result;
    logic             integ_stb;
    logic             integ_running;
    // Decoded strobes
    logic         wr_cfg, wr_start, wr_freq, wr_phase, wr_fstb, wr_pstb, wr_sync;
    logic         rd_result;
    logic         sync_load;

    sync_pulse_detect u_sync (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .pin_async (carrier_sync_input),
        .rise_ff   (sync_rise)
    );

    level_integrator #(
        .ACC_W (ACC_W),
        .CNT_W (18)
    ) u_integ (
        .sys_clk       (sys_clk),
        .sys_rst       (sys_rst),
        .start         (start_ff),
        .cont_mode     (cfg_ff.cont_mode),
        .interval      (cfg_ff.interval),
        .term          (term_ff),
        .result_ff     (integ_result),
        .result_stb_ff (integ_stb),
        .running_ff    (integ_running)
    );

    // Address decode; every strobe acts on the sample clock edge
    always_comb begin
        wr_cfg    = hit(reg_wr, reg_addr, `OFS_LVL_CFG);
        wr_start  = hit(reg_wr, reg_addr, `OFS_LVL_START);
        wr_freq   = hit(reg_wr, reg_addr, `OFS_FREQ_HOLD);
        wr_phase  = hit(reg_wr, reg_addr, `OFS_PHASE_HOLD);
        wr_fstb   = hit(reg_wr, reg_addr, `OFS_FREQ_STB);
        wr_pstb   = hit(reg_wr, reg_addr, `OFS_PHASE_STB);
        wr_sync   = hit(reg_wr, reg_addr, `OFS_NCO_SYNC_CFG);
        rd_result = hit(reg_rd, reg_addr, `OFS_LVL_RESULT);
        sync_load = sync_rise && sync_en_ff;
    end

    // Configuration words
    always_comb begin
        nxt_cfg      = cfg_ff;
        nxt_sync_en  = sync_en_ff;
        nxt_load_upd = load_upd_ff;
        nxt_interp   = interp_ff;
        if (wr_cfg) begin
            nxt_cfg.cont_mode = reg_wdata[`BIT_INTEG_MODE];
            nxt_cfg.interval  = reg_wdata[`INTERVAL_MSB:`INTERVAL_LSB];
            nxt_cfg.threshold = reg_wdata[`THRESH_MSB:0];
        end
        if (wr_sync) begin
            nxt_sync_en  = reg_wdata[`BIT_SYNC_EN];
            nxt_load_upd = reg_wdata[`BIT_LOAD_ON_UPD];
            nxt_interp   = reg_wdata[`BIT_INPUT_MODE];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfg_ff      <= '0;
            sync_en_ff  <= 1'b0;
            load_upd_ff <= 1'b0;
            interp_ff   <= 1'b0;
        end else begin
            cfg_ff      <= nxt_cfg;
            sync_en_ff  <= nxt_sync_en;
            load_upd_ff <= nxt_load_upd;
            interp_ff   <= nxt_interp;
        end
    end

    // Holding registers: writes here never disturb the running NCO
    always_comb begin
        nxt_freq_hold  = wr_freq  ? reg_wdata : freq_hold_ff;
        nxt_phase_hold = wr_phase ? reg_wdata[`PHASE_MSB:0] : phase_hold_ff;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            freq_hold_ff  <= `RST_WORD;
            phase_hold_ff <= `RST_PHASE;
        end else begin
            freq_hold_ff  <= nxt_freq_hold;
            phase_hold_ff <= nxt_phase_hold;
        end
    end

    // Transfer to the active registers on a strobe write or an enabled sync.
    // The strobe moves whatever the holding register held before this cycle,
    // so a hold write and a strobe in the same cycle cannot race.
    always_comb begin
        nxt_nco          = nco_ctrl_ff;
        nxt_nco.clear_fb = 1'b0;
        if (wr_fstb || sync_load) begin
            nxt_nco.freq = freq_hold_ff;
        end
        if (wr_pstb || sync_load) begin
            nxt_nco.phase = phase_hold_ff;
        end
        if (load_upd_ff && (wr_fstb || sync_load)) begin
            nxt_nco.clear_fb = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            nco_ctrl_ff <= '0;
        end else begin
            nco_ctrl_ff <= nxt_nco;
        end
    end

    // Input conditioning for the level detector.
    // Interpolated mode feeds zeros between samples; gated mode repeats the
    // last sample, so the threshold is integrated on every clock either way.
    always_comb begin
        logic [13:0] used;
        logic [13:0] mag;
        used = sample_data;
        mag  = '0;
        nxt_held_sample = sample_en ? sample_data : held_sample_ff;
        if (interp_ff) begin
            used = sample_en ? sample_data : 14'h0000;
        end else begin
            used = nxt_held_sample;
        end
        mag      = magnitude(used);
        nxt_term = $signed({2'b00, mag})
                 + $signed({{2{cfg_ff.threshold[13]}}, cfg_ff.threshold});
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            held_sample_ff <= '0;
            term_ff        <= '0;
        end else begin
            held_sample_ff <= nxt_held_sample;
            term_ff        <= nxt_term;
        end
    end

    // Start strobe: data is ignored, any write starts or restarts
    always_comb begin
        nxt_start = wr_start;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            start_ff <= 1'b0;
        end else begin
            start_ff <= nxt_start;
        end
    end

    // Result capture; a timeout wins over the clear by reading the result
    always_comb begin
        nxt_result = integ_stb ? 32'(integ_result) : result_ff;
        nxt_new    = level_new_ff;
        if (rd_result) begin
            nxt_new = 1'b0;
        end
        if (integ_stb) begin
            nxt_new = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            result_ff        <= `RST_WORD;
            level_new_ff     <= 1'b0;
            level_running_ff <= 1'b0;
        end else begin
            result_ff        <= nxt_result;
            level_new_ff     <= nxt_new;
            level_running_ff <= integ_running;
        end
    end

    // Read mux; write-only words and unmapped offsets read as zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == `OFS_LVL_RESULT) begin
                nxt_rdata = result_ff;
            end else if (reg_addr == `OFS_LVL_STATUS) begin
                nxt_rdata[`BIT_STAT_NEW] = level_new_ff;
                nxt_rdata[`BIT_STAT_RUN] = integ_running;
            end else if (reg_addr == `OFS_NCO_SYNC_CFG) begin
                nxt_rdata[`BIT_SYNC_EN]     = sync_en_ff;
                nxt_rdata[`BIT_INPUT_MODE]  = interp_ff;
                nxt_rdata[`BIT_LOAD_ON_UPD] = load_upd_ff;
            end else begin
                nxt_rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata_ff <= `RST_WORD;
        end else begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

endmodule // front_end_level_nco_control

// File: core/level_integrator.sv
`include "fe_ctrl_consts.svh"

module level_integrator
    import fe_ctrl_pkg::*;
#(
    parameter int ACC_W = 32,
    parameter int CNT_W = 18
) (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    // Control
    input  wire logic               start,
    input  wire logic               cont_mode,
    input  wire logic [15:0]        interval,
    input  wire logic signed [15:0] term,
    // Results
    output logic [ACC_W-1:0]        result_ff,
    output logic                    result_stb_ff,
    output logic                    running_ff
);

    integ_state_t       state_ff, nxt_state;
    logic [CNT_W-1:0]   cnt_ff, nxt_cnt, preload;
    logic [ACC_W-1:0]   acc_ff, nxt_acc, sum;
    logic [ACC_W-1:0]   nxt_result;
    logic               nxt_stb;

    // Field is the upper bits of the counter; one unit of bias gives N cycles
    always_comb begin
        preload = (interval == 16'h0000) ? '0 :
                  CNT_W'({interval, 2'b00} - `PRELOAD_BIAS);
        sum     = acc_ff + ACC_W'(term);
    end

    // Count down, integrate, and on timeout stop or reload
    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_acc    = acc_ff;
        nxt_result = result_ff;
        nxt_stb    = 1'b0;
        if (start) begin
            nxt_state = INTEG_RUN;
            nxt_cnt   = preload;
            nxt_acc   = '0;
        end else begin
            case (state_ff)
                INTEG_RUN: begin
                    if (cnt_ff <= CNT_W'(1)) begin
                        nxt_result = (cnt_ff == CNT_W'(1)) ? sum : acc_ff;
                        nxt_stb    = 1'b1;
                        nxt_acc    = '0;
                        if (cont_mode) begin
                            nxt_cnt = preload;
                        end else begin
                            nxt_state = INTEG_IDLE;
                        end
                    end else begin
                        nxt_acc = sum;
                        nxt_cnt = cnt_ff - CNT_W'(1);
                    end
                end
                default: begin
                    nxt_state = INTEG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_ff      <= INTEG_IDLE;
            cnt_ff        <= '0;
            acc_ff        <= '0;
            result_ff     <= '0;
            result_stb_ff <= 1'b0;
            running_ff    <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            cnt_ff        <= nxt_cnt;
            acc_ff        <= nxt_acc;
            result_ff     <= nxt_result;
            result_stb_ff <= nxt_stb;
            running_ff    <= (nxt_state == INTEG_RUN);
        end
    end

endmodule // level_integrator

// File: core/sync_pulse_detect.sv
module sync_pulse_detect
    import fe_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // Asynchronous pin and its rising-edge pulse
    input  wire logic pin_async,
    output logic      rise_ff
);

    logic meta_ff, stable_ff, last_ff;
    logic nxt_rise;

    // Only the second stage feeds the edge detector
    always_comb begin
        nxt_rise = stable_ff & ~last_ff;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_ff   <= 1'b0;
            stable_ff <= 1'b0;
            last_ff   <= 1'b0;
            rise_ff   <= 1'b0;
        end else begin
            meta_ff   <= pin_async;
            stable_ff <= meta_ff;
            last_ff   <= stable_ff;
            rise_ff   <= nxt_rise;
        end
    end

endmodule // sync_pulse_detect

// File: dv/front_end_level_nco_control_assertions.sv
`include "fe_ctrl_consts.svh"

module front_end_level_nco_control_assertions
    import fe_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_ff,
    // Outputs toward the datapath
    input wire nco_ctrl_t   nco_ctrl_ff,
    input wire logic        level_running_ff,
    input wire logic        level_new_ff
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] f_hold_ff;
    logic [9:0]  p_hold_ff;
    logic [15:0] ivl_ff;
    logic        cont_ff;
    logic        sync_en_ff;
    logic        lou_ff;
    logic [5:0]  sync_hist_ff;
    logic [19:0] cnt_ff;
    logic        wr_fstb;
    logic        wr_pstb;
    logic        wr_start;

    // Decoded strobe writes
    assign wr_fstb  = reg_wr && reg_addr == `OFS_FREQ_STB;
    assign wr_pstb  = reg_wr && reg_addr == `OFS_PHASE_STB;
    assign wr_start = reg_wr && reg_addr == `OFS_LVL_START;

    // Shadow of the written words; sync history hides late synchroniser hits
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            f_hold_ff    <= 32'h0;
            p_hold_ff    <= 10'h0;
            ivl_ff       <= 16'h0;
            cont_ff      <= 1'b0;
            sync_en_ff   <= 1'b0;
            lou_ff       <= 1'b0;
            sync_hist_ff <= 6'h0;
            cnt_ff       <= 20'h0;
        end else begin
            if (reg_wr && reg_addr == `OFS_FREQ_HOLD) f_hold_ff <= reg_wdata;
            if (reg_wr && reg_addr == `OFS_PHASE_HOLD) p_hold_ff <= reg_wdata[9:0];
            if (reg_wr && reg_addr == `OFS_LVL_CFG) begin
                cont_ff <= reg_wdata[30];
                ivl_ff  <= reg_wdata[29:14];
            end
            if (reg_wr && reg_addr == `OFS_NCO_SYNC_CFG) begin
                sync_en_ff <= reg_wdata[20];
                lou_ff     <= reg_wdata[0];
            end
            sync_hist_ff <= {sync_hist_ff[4:0], sync_en_ff};
            cnt_ff       <= wr_start ? 20'h1 : cnt_ff + 20'h1;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    a_freq_load: assert property (
        wr_fstb |=> nco_ctrl_ff.freq == $past(f_hold_ff))
        else $error("active frequency not loaded from hold");
    a_phase_load: assert property (
        wr_pstb |=> nco_ctrl_ff.phase == $past(p_hold_ff))
        else $error("active phase not loaded from hold");
    a_freq_steady: assert property (
        $changed(nco_ctrl_ff.freq) && sync_hist_ff == 6'h0 && !sync_en_ff |-> $past(wr_fstb))
        else $error("active frequency changed without a transfer");
    a_clear_on_upd: assert property (
        wr_fstb && lou_ff |=> nco_ctrl_ff.clear_fb)
        else $error("feedback clear missing after frequency strobe");
    a_clear_cause: assert property (
        nco_ctrl_ff.clear_fb |-> $past(lou_ff) && ($past(wr_fstb) || sync_hist_ff != 6'h0))
        else $error("feedback clear without a cause");
    a_read_idle: assert property (
        !$past(reg_rd) |-> reg_rdata_ff == 32'h0)
        else $error("read data not zero outside read cycle");
    a_start_run: assert property (
        wr_start |-> ##[2:3] level_running_ff)
        else $error("integrator not running after start");
    // N = 4*(field-1) terms, plus start, stop and flag registers, seen one edge late
    a_result_time: assert property (
        $rose(level_new_ff) && !cont_ff |-> cnt_ff == {2'b00, ivl_ff, 2'b00} - 20'h1)
        else $error("result at wrong interval");
    a_stop_once: assert property (
        $rose(level_new_ff) && !cont_ff |-> ##[0:3] !level_running_ff)
        else $error("integrator keeps running in single mode");
    a_cont_runs: assert property (
        $fell(level_running_ff) |-> !cont_ff)
        else $error("integrator stopped in continuous mode");
endmodule // front_end_level_nco_control_assertions

bind front_end_level_nco_control front_end_level_nco_control_assertions chk (
    .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff,
    .nco_ctrl_ff, .level_running_ff, .level_new_ff);

// File: dv/front_end_level_nco_control_bench.sv
`include "fe_ctrl_consts.svh"

module front_end_level_nco_control_bench
    import fe_ctrl_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk;
    logic        sys_rst;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata_ff;
    logic [13:0] sample_data;
    logic        sample_en;
    logic        carrier_sync_input;
    nco_ctrl_t   nco_ctrl_ff;
    logic        level_running_ff;
    logic        level_new_ff;
    logic [31:0] rv;
    int          fail_count = 0;
    int          n_compared = 0;
    int          n_clear = 0;
    int          nc;

    // 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    front_end_level_nco_control #(.ACC_W(32)) dut (
        .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff,
        .sample_data, .sample_en, .carrier_sync_input, .nco_ctrl_ff,
        .level_running_ff, .level_new_ff);

    uproc_model cpu (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff);

    // Count feedback-clear pulses, one per cycle seen high
    always @(posedge sys_clk) begin
        if (nco_ctrl_ff.clear_fb === 1'b1) n_clear++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        cpu.rd(a, rv);
        check(rv, exp);
    endtask

    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Bounded wait for a fresh integration result
    task automatic wait_new;
        for (int i = 0; i < 300 && level_new_ff !== 1'b1; i++) @(posedge sys_clk);
        if (level_new_ff !== 1'b1) begin
            check({31'h0, level_new_ff}, 32'h1);
            give_verdict();
        end
    endtask

    // Sync pin pulse, then time for the two-flop synchroniser
    task automatic sync_pulse;
        @(posedge sys_clk);
        carrier_sync_input <= 1'b1;
        repeat (3) @(posedge sys_clk);
        carrier_sync_input <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask

    initial begin
        sys_rst = 1'b1;
        sample_data = 14'h3ED4;
        sample_en = 1'b0;
        carrier_sync_input = 1'b0;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);

        // Reset values, write-only and unmapped reads
        rd_chk(`OFS_LVL_STATUS, 32'h0);
        rd_chk(`OFS_NCO_SYNC_CFG, 32'h0);
        rd_chk(8'h24, 32'h0);
        cpu.wr(`OFS_LVL_CFG, 32'h7FFF_FFFF);
        rd_chk(`OFS_LVL_CFG, 32'h0);
        cpu.wr(`OFS_NCO_SYNC_CFG, 32'h0000_0001);
        rd_chk(`OFS_NCO_SYNC_CFG, 32'h0000_0001);
        $display("test registers done");

        // Holding registers only move on their strobes
        cpu.wr(`OFS_FREQ_HOLD, 32'h8000_0001);
        cpu.wr(`OFS_PHASE_HOLD, 32'hFFFF_FE01);
        check(nco_ctrl_ff.freq, 32'h0);
        nc = n_clear;
        cpu.wr(`OFS_FREQ_STB, 32'h0);
        check(nco_ctrl_ff.freq, 32'h8000_0001);
        check({22'h0, nco_ctrl_ff.phase}, 32'h0);
        cpu.wr(`OFS_PHASE_STB, 32'h0);
        check({22'h0, nco_ctrl_ff.phase}, 32'h201);
        @(posedge sys_clk);
        #1;
        check(32'(n_clear), 32'(nc + 1));
        $display("test strobes done");

        // Sync pin ignored when disabled, transfers both words when enabled
        cpu.wr(`OFS_FREQ_HOLD, 32'h1234_5678);
        cpu.wr(`OFS_PHASE_HOLD, 32'h0000_03FF);
        sync_pulse();
        check(nco_ctrl_ff.freq, 32'h8000_0001);
        cpu.wr(`OFS_NCO_SYNC_CFG, 32'h0010_0001);
        nc = n_clear;
        sync_pulse();
        check(nco_ctrl_ff.freq, 32'h1234_5678);
        check({22'h0, nco_ctrl_ff.phase}, 32'h3FF);
        check(32'(n_clear), 32'(nc + 1));
        $display("test sync done");

        // Single mode, gated input held at -300, threshold -100, restart mid-run
        cpu.wr(`OFS_NCO_SYNC_CFG, 32'h0);
        @(posedge sys_clk);
        sample_en <= 1'b1;
        @(posedge sys_clk);
        sample_en <= 1'b0;
        cpu.wr(`OFS_LVL_CFG, cpu.lvl_word(1'b0, 8, 14'h3F9C));
        cpu.wr(`OFS_LVL_START, 32'hDEAD_BEEF);
        cpu.wr(`OFS_LVL_START, 32'h0);
        wait_new();
        rd_chk(`OFS_LVL_RESULT, 32'h0000_0640);
        repeat (4) @(posedge sys_clk);
        rd_chk(`OFS_LVL_STATUS, 32'h0);
        $display("test single done");

        // Continuous mode, interpolated zeros add only the threshold
        cpu.wr(`OFS_NCO_SYNC_CFG, 32'h0002_0000);
        cpu.wr(`OFS_LVL_CFG, cpu.lvl_word(1'b1, 16, 14'h3F9C));
        cpu.wr(`OFS_LVL_START, 32'h0);
        repeat (2) begin
            wait_new();
            rd_chk(`OFS_LVL_RESULT, 32'hFFFF_F9C0);
            rd_chk(`OFS_LVL_STATUS, 32'h0000_0002);
        end
        $display("test continuous done");
        give_verdict();
    end
endmodule // front_end_level_nco_control_bench

// File: dv/uproc_model.sv
module uproc_model (
    // Clock
    input  wire logic        sys_clk,
    // Register port toward the block
    output logic [7:0]       reg_addr,
    output logic [31:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata_ff
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus at time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One-cycle write; released lines flip so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
        #1;
    endtask

    // One-cycle read; data is taken in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata_ff;
    endtask

    // Level word: interval field is period/4 + 1, period a multiple of four
    function automatic logic [31:0] lvl_word(logic cont, int n, logic [13:0] th);
        return {1'b0, cont, 16'(n / 4 + 1), th};
    endfunction
endmodule // uproc_model
